// ---- i2c_regs_pkg.sv ----
package i2c_regs_pkg;

   // ***********************************************************
   // register map, byte addresses on the apb bus
   // ***********************************************************
   localparam int               ADDR_W        = 8;
   localparam logic [ADDR_W-1:0] OFF_DATA      = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_ADDR_MODE = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_CTRL      = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_STATUS    = 8'h0C;

   // ***********************************************************
   // field positions
   // ***********************************************************
   localparam int FS_BIT        = 0;
   localparam int ORDER_BIT     = 7;
   localparam int WAIT_BIT      = 6;
   localparam int CTRL_IEN_BIT  = 7;
   localparam int CTRL_TX_BIT   = 4;
   localparam int CTRL_ACKM_BIT = 3;
   localparam int STAT_FLAG_BIT = 0;
   localparam int STAT_ADDR_BIT = 1;
   localparam int STAT_WAIT_BIT = 2;
   localparam int STAT_BUSY_BIT = 3;
   localparam int STAT_NACK_BIT = 4;

   // ***********************************************************
   // reset values, fixed bits and the full byte count
   // ***********************************************************
   localparam logic [7:0] ADDR_RESET  = 8'h00;
   localparam logic [7:0] MODE_RESET  = 8'h38;
   localparam logic [7:0] MODE_FIXED  = 8'h38;
   localparam logic [3:0] FULL_BYTE   = 4'h8;

   // ***********************************************************
   // types
   // ***********************************************************
   typedef enum logic [1:0] {
      PH_IDLE,
      PH_BITS,
      PH_WAIT,
      PH_ACK
   } phase_e;

   typedef struct packed {
      logic scl;
      logic sda;
   } line_s;

endpackage : i2c_regs_pkg

// ---- pin_sync.sv ----
`timescale 1ns/100ps
module pin_sync
   import i2c_regs_pkg::*;
#(
   parameter int          WIDTH = 2,
   parameter logic [WIDTH-1:0] IDLE = '1
) (
   // clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // pins and filtered levels
   input  wire logic [WIDTH-1:0] raw,
   output      logic [WIDTH-1:0] clean
);

   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] q;
   } sync_s;

   sync_s r;
   sync_s next_r;
   logic [WIDTH-1:0] next_q;

   // a level counts only once the second and third stages agree
   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      assign next_q[i] = (r.s2[i] == r.s3[i]) ? r.s2[i] : r.q[i];
   end

   always_comb begin
      next_r    = r;
      next_r.s1 = raw;
      next_r.s2 = r.s1;
      next_r.s3 = r.s2;
      next_r.q  = next_q;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '{s1: IDLE, s2: IDLE, s3: IDLE, q: IDLE};
      end else begin
         r <= next_r;
      end
   end

   assign clean = r.q;

endmodule : pin_sync

// ---- i2c_data_addr_mode_regs.sv ----
`timescale 1ns/100ps
module i2c_data_addr_mode_regs
   import i2c_regs_pkg::*;
(
   // clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output      logic [31:0]       prdata,
   output      logic              pready,
   output      logic              pslverr,
   // serial clock, open drain
   input  wire logic              scl_in,
   output      logic              scl_out,
   output      logic              scl_oe_n,
   // serial data, open drain
   input  wire logic              sda_in,
   output      logic              sda_out,
   output      logic              sda_oe_n
);

   // ***********************************************************
   // state
   // ***********************************************************
   typedef struct packed {
      phase_e      ph;
      logic [3:0]  cnt;
      logic [7:0]  shift;
      logic [7:0]  own_addr;
      logic [7:0]  mode;
      logic        ien;
      logic        tx;
      logic        ackm;
      logic        flag;
      logic        addressed;
      logic        addr_ph;
      logic        go;
      logic        nack;
      line_s       prev;
      logic        scl_oe_n;
      logic        sda_oe_n;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } state_s;

   state_s      r;
   state_s      next_r;
   line_s       ln;
   logic [1:0]  ln_vec;

   pin_sync #(
      .WIDTH (2),
      .IDLE  (2'h3)
   ) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .raw     ({scl_in, sda_in}),
      .clean   (ln_vec)
   );
   assign ln = line_s'(ln_vec);

   // ***********************************************************
   // decode and bus events
   // ***********************************************************
   logic        setup;
   logic        access;
   logic        mapped;
   logic        rise;
   logic        fall;
   logic        start_det;
   logic        stop_det;
   logic [3:0]  nbits;
   logic        receiving;
   logic        sel;
   logic        engaged;
   logic        match;
   logic        lsb_first;
   logic        frame_end;
   logic [31:0] rd_word;

   assign setup     = psel && !penable;
   assign access    = psel && penable && r.pready;
   assign mapped    = (paddr == OFF_DATA) || (paddr == OFF_ADDR_MODE)
                   || (paddr == OFF_CTRL) || (paddr == OFF_STATUS);
   assign rise      = !r.prev.scl && ln.scl;
   assign fall      = r.prev.scl && !ln.scl;
   assign start_det = r.prev.scl && ln.scl && r.prev.sda && !ln.sda;
   assign stop_det  = r.prev.scl && ln.scl && !r.prev.sda && ln.sda;
   assign nbits     = (r.mode[2:0] == 3'h0) ? FULL_BYTE
                                            : {1'b0, r.mode[2:0]};
   assign receiving = r.addr_ph || !r.tx;
   assign sel       = r.addressed || r.own_addr[FS_BIT];
   assign engaged   = r.addr_ph || (sel && r.go);
   assign match     = r.shift[7:1] == r.own_addr[7:1];
   assign lsb_first = r.mode[ORDER_BIT];

   always_comb begin
      rd_word = 32'h00000000;
      case (paddr)
         OFF_DATA:      rd_word[7:0] = r.shift;
         // one offset, two registers, steered by the enable
         OFF_ADDR_MODE: rd_word[7:0] = r.ien ? (r.mode | MODE_FIXED)
                                             : r.own_addr;
         OFF_CTRL: begin
            rd_word[CTRL_IEN_BIT]  = r.ien;
            rd_word[CTRL_TX_BIT]   = r.tx;
            rd_word[CTRL_ACKM_BIT] = r.ackm;
         end
         OFF_STATUS: begin
            rd_word[STAT_FLAG_BIT] = r.flag;
            rd_word[STAT_ADDR_BIT] = r.addressed;
            rd_word[STAT_WAIT_BIT] = r.ph == PH_WAIT;
            rd_word[STAT_BUSY_BIT] = r.ph != PH_IDLE;
            rd_word[STAT_NACK_BIT] = r.nack;
         end
         default: rd_word = 32'h00000000;
      endcase
   end

   // ***********************************************************
   // next state
   // ***********************************************************
   always_comb begin
      next_r         = r;
      frame_end      = 1'b0;
      next_r.pready  = 1'b0;
      next_r.pslverr = 1'b0;
      next_r.prev    = ln;

      // every access answers after one wait-free access phase
      if (setup) begin
         next_r.pready  = 1'b1;
         next_r.pslverr = !mapped;
         next_r.prdata  = rd_word;
      end

      // software side first, so that hardware sets below win
      if (access && pwrite) begin
         case (paddr)
            OFF_DATA: begin
               next_r.shift = pwdata[7:0];
               next_r.go    = 1'b1;
            end
            OFF_ADDR_MODE: begin
               if (r.ien) begin
                  next_r.mode = pwdata[7:0] | MODE_FIXED;
               end else begin
                  next_r.own_addr = pwdata[7:0];
               end
            end
            OFF_CTRL: begin
               next_r.ien  = pwdata[CTRL_IEN_BIT];
               next_r.tx   = pwdata[CTRL_TX_BIT];
               next_r.ackm = pwdata[CTRL_ACKM_BIT];
            end
            OFF_STATUS: begin
               if (pwdata[STAT_FLAG_BIT]) begin
                  next_r.flag = 1'b0;
               end
            end
            default: ;
         endcase
      end else if (access && paddr == OFF_DATA && !r.tx) begin
         next_r.go = 1'b1;
      end

      if (!r.ien) begin
         next_r.ph        = PH_IDLE;
         next_r.cnt       = 4'h0;
         next_r.addressed = 1'b0;
         next_r.addr_ph   = 1'b0;
      end else if (start_det) begin
         next_r.ph        = PH_BITS;
         next_r.cnt       = 4'h0;
         next_r.addr_ph   = !r.own_addr[FS_BIT];
         next_r.addressed = 1'b0;
         next_r.nack      = 1'b0;
      end else if (stop_det) begin
         next_r.ph        = PH_IDLE;
         next_r.cnt       = 4'h0;
         next_r.addressed = 1'b0;
         next_r.addr_ph   = 1'b0;
      end else begin
         case (r.ph)
            PH_BITS: begin
               if (engaged && rise) begin
                  next_r.cnt = 4'(r.cnt + 4'h1);
                  if (receiving) begin
                     next_r.shift = lsb_first ? {ln.sda, r.shift[7:1]}
                                              : {r.shift[6:0], ln.sda};
                  end
               end else if (engaged && fall && r.cnt == nbits) begin
                  if (r.addr_ph && !match) begin
                     // not for us: stay off the bus until the next start
                     next_r.ph      = PH_IDLE;
                     next_r.addr_ph = 1'b0;
                  end else begin
                     if (r.addr_ph) begin
                        next_r.addressed = 1'b1;
                        next_r.tx        = r.shift[0];
                     end
                     if (r.ackm) begin
                        frame_end = 1'b1;
                     end else if (r.mode[WAIT_BIT]) begin
                        next_r.ph   = PH_WAIT;
                        next_r.flag = 1'b1;
                     end else begin
                        next_r.ph = PH_ACK;
                     end
                  end
               end else if (engaged && fall && r.cnt != 4'h0
                            && !receiving) begin
                  next_r.shift = lsb_first ? {1'b0, r.shift[7:1]}
                                           : {r.shift[6:0], 1'b0};
               end
            end
            PH_WAIT: begin
               if (!r.flag) begin
                  next_r.ph = PH_ACK;
               end
            end
            PH_ACK: begin
               if (rise) begin
                  next_r.cnt = 4'(r.cnt + 4'h1);
                  if (!receiving) begin
                     next_r.nack = ln.sda;
                  end
               end else if (fall && r.cnt == 4'(nbits + 4'h1)) begin
                  frame_end = 1'b1;
               end
            end
            default: next_r.ph = PH_IDLE;
         endcase
      end

      if (frame_end) begin
         next_r.ph      = PH_BITS;
         next_r.cnt     = 4'h0;
         next_r.go      = 1'b0;
         next_r.addr_ph = 1'b0;
         next_r.flag    = 1'b1;
      end

      // pins: low enable pulls the wire low, disabled means released
      next_r.scl_oe_n = 1'b1;
      next_r.sda_oe_n = 1'b1;
      if (r.ien) begin
         if (next_r.ph == PH_WAIT
             || (next_r.ph == PH_BITS && (r.addressed || r.own_addr[FS_BIT])
                 && !next_r.addr_ph && !next_r.go
                 && next_r.cnt == 4'h0 && !ln.scl)) begin
            next_r.scl_oe_n = 1'b0;
         end
         if (next_r.ph == PH_ACK && (next_r.addr_ph || !next_r.tx)) begin
            next_r.sda_oe_n = 1'b0;
         end else if (next_r.ph == PH_BITS && next_r.tx && next_r.go
                      && !next_r.addr_ph && next_r.addressed | r.own_addr[0]
                      && next_r.cnt <= nbits) begin
            next_r.sda_oe_n = lsb_first ? next_r.shift[0]
                                        : next_r.shift[7];
         end
      end
   end

   // ***********************************************************
   // registers
   // ***********************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r          <= '0;
         r.ph       <= PH_IDLE;
         r.own_addr <= ADDR_RESET;
         r.mode     <= MODE_RESET;
         r.prev     <= '{scl: 1'b1, sda: 1'b1};
         r.scl_oe_n <= 1'b1;
         r.sda_oe_n <= 1'b1;
      end else begin
         r <= next_r;   // shift data is cleared but carries no meaning
      end
   end

   assign prdata   = r.prdata;
   assign pready   = r.pready;
   assign pslverr  = r.pslverr;
   assign scl_oe_n = r.scl_oe_n;
   assign sda_oe_n = r.sda_oe_n;
   assign scl_out  = 1'b0;
   assign sda_out  = 1'b0;

   // ***********************************************************
   // checks
   // ***********************************************************
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   release_off_a: assert property (
      !r.ien |=> r.scl_oe_n && r.sda_oe_n)
      else $error("pins driven while interface disabled");

   fixed_ones_a: assert property (
      setup && !pwrite && paddr == OFF_ADDR_MODE && r.ien
      |=> prdata[5:3] == 3'h7)
      else $error("reserved mode bits not read as ones");

   wait_flag_a: assert property (
      r.ph != PH_WAIT ##1 r.ph == PH_WAIT |-> r.flag && !r.scl_oe_n)
      else $error("wait entered without flag or scl hold");

   no_wait_a: assert property (
      r.ph != PH_WAIT ##1 r.ph == PH_WAIT
      |-> $past(r.mode[WAIT_BIT]) && !$past(r.ackm))
      else $error("wait entered without wait bit");

   wait_hold_a: assert property (
      r.ph == PH_WAIT && r.flag && !start_det && !stop_det && r.ien
      |=> r.ph == PH_WAIT)
      else $error("wait left before flag cleared");

   start_clear_a: assert property (
      r.ien && start_det |=> r.cnt == 4'h0 && r.ph == PH_BITS)
      else $error("start did not clear bit counter");

   frame_clear_a: assert property (
      r.ien && frame_end && !start_det && !stop_det
      |=> r.cnt == 4'h0 && r.flag && !r.go)
      else $error("frame end did not clear counter");

   tx_arm_a: assert property (
      access && pwrite && paddr == OFF_DATA
      |=> r.go && r.shift == $past(pwdata[7:0]))
      else $error("data write did not arm transfer");

   rx_arm_a: assert property (
      access && !pwrite && paddr == OFF_DATA && !r.tx |=> r.go)
      else $error("data read did not arm receive");

   addr_write_a: assert property (
      access && pwrite && paddr == OFF_ADDR_MODE && !r.ien
      |=> r.own_addr == $past(pwdata[7:0]) && r.mode[5:3] == 3'h7)
      else $error("shared offset reached wrong register");

   addr_match_a: assert property (
      r.ien && r.ph == PH_BITS && r.addr_ph && fall && r.cnt == nbits
      && match && !start_det && !stop_det
      |=> r.addressed && r.tx == $past(r.shift[0]))
      else $error("matching address not taken");

endmodule : i2c_data_addr_mode_regs

// ---- i2c_master_model.sv ----
`timescale 1ns/100ps
module i2c_master_model (
   // resolved bus lines
   input  wire logic scl,
   input  wire logic sda,
   // pulls, high drags the line low
   output      logic scl_pull,
   output      logic sda_pull
);
   initial begin
      scl_pull = 1'b0;
      sda_pull = 1'b0;
   end

   // ******************************
   // bus conditions
   // ******************************
   task automatic start_cond;
      sda_pull = 1'b1;
      #80;
      scl_pull = 1'b1;
      #40;
   endtask : start_cond

   task automatic stop_cond;
      sda_pull = 1'b1;
      #40;
      scl_pull = 1'b0;
      wait (scl);
      #80;
      sda_pull = 1'b0;
      #80;
   endtask : stop_cond

   // sends tx[n-1:0]; a 1 releases sda so the slave may drive it
   task automatic xfer(input logic [8:0] tx, input int n,
                       output logic [8:0] rx);
      rx = '0;
      for (int i = n - 1; i >= 0; i--) begin
         sda_pull = ~tx[i];
         #40;
         scl_pull = 1'b0;
         // slave may stretch the low phase
         wait (scl);
         #40;
         rx[i] = sda;
         #40;
         scl_pull = 1'b1;
         #40;
      end
      sda_pull = 1'b0;
   endtask : xfer
endmodule : i2c_master_model

// ---- tb.sv ----
`timescale 1ns/100ps
module tb
   import i2c_regs_pkg::*;
;
   // chosen to differ from any other slave on the bus
   localparam logic [6:0] own_addr = 7'h5A;
   logic              pclk, presetn, psel, penable, pwrite, ack_done;
   logic [ADDR_W-1:0] paddr;
   logic [31:0]       pwdata, prdata;
   logic              pready, pslverr, scl_out, scl_oe_n, sda_out, sda_oe_n;
   logic              scl_pull, sda_pull, scl, sda;
   int                err_count, n_compared, cycles;

   // open drain wires with pull-ups
   assign scl = (scl_oe_n ? 1'b1 : scl_out) & ~scl_pull;
   assign sda = (sda_oe_n ? 1'b1 : sda_out) & ~sda_pull;

   i2c_data_addr_mode_regs DUT (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .scl_in(scl), .scl_out(scl_out),
      .scl_oe_n(scl_oe_n), .sda_in(sda), .sda_out(sda_out),
      .sda_oe_n(sda_oe_n));
   i2c_master_model master (.scl(scl), .sda(sda), .scl_pull(scl_pull),
                            .sda_pull(sda_pull));

   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_count = err_count + 1;
         $display("Error %0t: timeout", $time);
         print_verdict;
      end
   end

   // ******************************
   // helpers
   // ******************************
   task automatic print_verdict;
      $display("compared %0d errors %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : print_verdict

   task automatic check(input logic [31:0] got, input logic [31:0] exp,
                        input string what);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("Error %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask : check

   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [7:0] wd, output logic [31:0] rd,
                      output logic err);
      int n;
      n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= {24'h000000, wd};
      @(posedge pclk);
      penable <= 1'b1;
      // sample ready at the rising edge, hold the request until then
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50) begin
         n++;
         @(posedge pclk);
      end
      if (pready !== 1'b1) begin
         err_count++;
         $display("Error %0t: no apb answer", $time);
      end
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] x;
      logic        e;
      apb(1'b1, a, d, x, e);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      logic e;
      apb(1'b0, a, 8'h00, d, e);
   endtask : rd

   // data register is touched only once the frame has ended
   task automatic wait_flag;
      logic [31:0] d;
      int          n;
      n = 0;
      d = '0;
      while (d[STAT_FLAG_BIT] !== 1'b1 && n < 400) begin
         rd(OFF_STATUS, d);
         n++;
      end
      check(d[STAT_FLAG_BIT], 1'b1, "flag");
   endtask : wait_flag

   // ******************************
   // scenarios
   // ******************************
   task automatic t_regs;
      logic [31:0] s;
      logic        e;
      rd(OFF_ADDR_MODE, s);
      check(s, ADDR_RESET, "address reset");
      check({scl_oe_n, sda_oe_n}, 2'b11, "pins released");
      wr(OFF_ADDR_MODE, {own_addr, 1'b0});
      rd(OFF_ADDR_MODE, s);
      check(s, {own_addr, 1'b0}, "own address");
      check({scl_out, sda_out}, 2'b00, "open drain data");
      apb(1'b0, 8'h40, 8'h00, s, e);
      check(e, 1'b1, "unmapped error");
      check(s, 32'h00000000, "unmapped data");
      wr(OFF_CTRL, 8'h80);
      rd(OFF_ADDR_MODE, s);
      check(s, MODE_RESET, "mode reset");
      wr(OFF_ADDR_MODE, 8'h07);
      rd(OFF_ADDR_MODE, s);
      check(s, 8'h3F, "fixed bits");
      wr(OFF_ADDR_MODE, 8'h00);
   endtask : t_regs

   task automatic t_rx(input logic [7:0] mode, input int nb,
                       input logic [7:0] data, input logic [7:0] exp,
                       input logic [7:0] mask);
      logic [8:0]  r;
      logic [31:0] s;
      ack_done = 1'b0;
      fork
         begin
            master.start_cond;
            master.xfer({own_addr, 2'b01}, 9, r);
            check(r[0], 1'b0, "address ack");
            master.xfer({data, 1'b1}, nb, r);
            ack_done = 1'b1;
            check(r[0], 1'b0, "data ack");
            master.stop_cond;
         end
         begin
            wait_flag;
            rd(OFF_STATUS, s);
            check(s[STAT_ADDR_BIT], 1'b1, "addressed");
            wr(OFF_STATUS, 8'h01);
            wr(OFF_ADDR_MODE, mode);
            rd(OFF_DATA, s);
            wait_flag;
            rd(OFF_STATUS, s);
            check(s[STAT_WAIT_BIT], mode[WAIT_BIT], "wait");
            if (mode[WAIT_BIT]) begin
               check(scl_oe_n, 1'b0, "scl held");
               check(ack_done, 1'b0, "ack early");
               wr(OFF_STATUS, 8'h01);
               wait_flag;
            end
            wr(OFF_STATUS, 8'h01);
            rd(OFF_DATA, s);
            check(s & mask, exp & mask, "received");
         end
      join
      wr(OFF_ADDR_MODE, 8'h00);
   endtask : t_rx

   task automatic t_nomatch;
      logic [8:0] r;
      master.start_cond;
      master.xfer({own_addr ^ 7'h01, 2'b01}, 9, r);
      check(r[0], 1'b1, "foreign address");
      master.stop_cond;
   endtask : t_nomatch

   task automatic t_tx;
      logic [8:0] r;
      fork
         begin
            master.start_cond;
            master.xfer({own_addr, 2'b11}, 9, r);
            master.xfer(9'h1FE, 9, r);
            check(r[8:1], 8'hC3, "sent byte");
         end
         begin
            wait_flag;
            wr(OFF_STATUS, 8'h01);
            wr(OFF_DATA, 8'hC3);
         end
      join
   endtask : t_tx

   initial begin
      presetn    = 1'b0;
      psel       = 1'b0;
      penable    = 1'b0;
      pwrite     = 1'b0;
      paddr      = '0;
      pwdata     = '0;
      ack_done   = 1'b0;
      err_count  = 0;
      n_compared = 0;
      cycles     = 0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_rx(8'h00, 9, 8'hA5, 8'hA5, 8'hFF);
      t_rx(8'h80, 9, 8'h1E, 8'h78, 8'hFF);
      t_rx(8'h40, 9, 8'h3C, 8'h3C, 8'hFF);
      t_rx(8'h03, 4, 8'h05, 8'h05, 8'h07);
      t_nomatch;
      t_tx;
      print_verdict;
   end
endmodule : tb
